// ==== hdl/rf_check_pkg.sv ====
// Package for the RF collision check sequencer (host side).
// Assumes one 20 MHz clock and an APB slave for the controller's own registers.
package rf_check_pkg;

  // Transceiver register map, reached through the device port
  localparam logic [4:0] XCVR_CHIP_CTRL_ADDR   = 5'h00;
  localparam logic [4:0] XCVR_FIELD_LEVEL_ADDR = 5'h0f;
  localparam logic [7:0] CHIP_CTRL_RX_ONLY_3V  = 8'h02;
  localparam logic [7:0] CHIP_CTRL_RX_ONLY_5V  = 8'h03;
  localparam logic [7:0] CMD_TEST_EXT_FIELD    = 8'h19;
  localparam logic [7:0] NFCA_POLL_REQUEST     = 8'h26;
  localparam logic [7:0] NFCA_WAKEUP_REQUEST   = 8'h52;
  localparam int         FIELD_CODE_MSB        = 2;
  localparam logic [2:0] FIELD_CODE_QUIET      = 3'h0;

  // Initial bit rates in kbps per technology
  localparam logic [9:0] RATE_TYPE_A_KBPS      = 10'h06a;
  localparam logic [9:0] RATE_TYPE_B_KBPS      = 10'h06a;
  localparam logic [9:0] RATE_F_LOW_KBPS       = 10'h0d4;
  localparam logic [9:0] RATE_F_HIGH_KBPS      = 10'h1a8;

  // Timing
  localparam int CLK_HZ          = 20000000;
  localparam int MEAS_WAIT_US    = 50;
  localparam int MEAS_WAIT_CYC   = (MEAS_WAIT_US * (CLK_HZ / 1000000));
  localparam int MS_CYC          = CLK_HZ / 1000;
  localparam int POLL_PERIOD_MS  = 500;

  // Own APB register map (byte addresses)
  localparam logic [7:0] REG_CTRL_OFS    = 8'h00;
  localparam logic [7:0] REG_BACKOFF_OFS = 8'h04;
  localparam logic [7:0] REG_STATUS_OFS  = 8'h08;
  localparam logic [7:0] REG_RESULT_OFS  = 8'h0c;
  localparam int CTRL_START_BIT  = 0;
  localparam int CTRL_5V_BIT     = 1;
  localparam int CTRL_WAKEUP_BIT = 2;
  localparam int CTRL_F424_BIT   = 3;
  localparam logic [15:0] BACKOFF_RESET_MS = 16'h000a;

  // Polling order within one period
  typedef enum logic [2:0] {
    TECH_ACTIVE_A, TECH_ACTIVE_F, TECH_PASSIVE_A,
    TECH_PASSIVE_B, TECH_PASSIVE_F, TECH_PASSIVE_V
  } tech_t;

  // Request toward the transceiver access engine
  typedef struct packed {
    logic       valid;
    logic       is_cmd;
    logic       is_read;
    logic [4:0] addr;
    logic [7:0] data;
  } xcvr_req_t;

  // One poll slot handed to the outside
  typedef struct packed {
    logic       valid;
    tech_t      tech;
    logic [7:0] first_cmd;
    logic [9:0] rate_kbps;
  } poll_slot_t;

endpackage

// ==== hdl/xcvr_access.sv ====
// Byte-serial access engine toward the transceiver port.
// Assumes a simple strobe/ack device port; one access outstanding at a time.
`timescale 1ns/1ns
module xcvr_access (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // Request side
  input  wire rf_check_pkg::xcvr_req_t req,
  output logic                        done,
  output logic [7:0]                  rdata,
  // Device port
  output logic                        dev_stb,
  output logic                        dev_cmd,
  output logic                        dev_we,
  output logic [4:0]                  dev_addr,
  output logic [7:0]                  dev_wdata,
  input  wire logic                   dev_ack,
  input  wire logic [7:0]             dev_rdata
);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dev_stb   <= 1'b0;
      dev_cmd   <= 1'b0;
      dev_we    <= 1'b0;
      dev_addr  <= 5'h00;
      dev_wdata <= 8'h00;
      done      <= 1'b0;
      rdata     <= 8'h00;
    end else begin
      done <= 1'b0;
      if (dev_stb) begin
        if (dev_ack) begin
          dev_stb <= 1'b0;
          done    <= 1'b1;
          rdata   <= dev_rdata;
        end
      end else if (req.valid && !done) begin
        dev_stb   <= 1'b1;
        dev_cmd   <= req.is_cmd;
        dev_we    <= !req.is_read;
        dev_addr  <= req.addr;
        dev_wdata <= req.data;
      end
    end
  end

endmodule

// ==== hdl/rf_collision_check_sequencer.sv ====
// Host-side sequencer: RF collision check, backoff and polling order.
// Assumes an APB master for its registers and a strobe/ack transceiver port.
//
// Functional notes
// - Keep own field off while code nonzero
// - Write receive-only value to chip control
// - Then issue external field test command
// - Wait 50 us before reading result
// - Read field register, take bits 2-0
// - Nonzero code: stay target, back off
// - Zero code: proceed initiator or target
// - Repeat polling period every 500 ms
// - Poll active A,F then passive A,B,F,V
// - NFC-A poll uses request command 0x26
// - Wake-up command 0x52 as alternative
// - Type A and B start 106 kbps
// - Type F starts 212 or 424 kbps
`timescale 1ns/1ns
module rf_collision_check_sequencer #(
  parameter int MS_CYCLES      = rf_check_pkg::MS_CYC,
  parameter int PERIOD_MS      = rf_check_pkg::POLL_PERIOD_MS,
  parameter int SLOT_CYCLES    = 1000
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic                          pready,
  output logic [31:0]                   prdata,
  output logic                          pslverr,
  // Transceiver port
  output logic                          dev_stb,
  output logic                          dev_cmd,
  output logic                          dev_we,
  output logic [4:0]                    dev_addr,
  output logic [7:0]                    dev_wdata,
  input  wire logic                     dev_ack,
  input  wire logic [7:0]               dev_rdata,
  // Mode and poll slot outputs
  output logic                          field_on,
  output logic                          target_mode,
  output rf_check_pkg::poll_slot_t      poll_slot
);

  localparam int MEAS_CYC = rf_check_pkg::MEAS_WAIT_CYC;

  typedef enum logic [3:0] {
    S_IDLE, S_RXCFG, S_TEST, S_WAIT, S_READ, S_DECIDE,
    S_BACKOFF, S_POLL, S_LISTEN
  } state_t;

  state_t                  state_reg;
  rf_check_pkg::xcvr_req_t req_reg;
  logic                    acc_done;
  logic [7:0]              acc_rdata;
  logic [31:0]             ctrl_reg;
  logic [15:0]             backoff_ms_reg;
  logic [2:0]              code_reg;
  logic                    backed_off_reg;
  logic [31:0]             cnt_reg;
  logic [15:0]             ms_left_reg;
  logic [31:0]             period_cnt_reg;
  logic                    period_tick;
  logic [2:0]              tech_idx_reg;
  logic                    out_field_reg;
  logic                    out_target_reg;
  logic                    req_busy_reg;
  logic [31:0]             slot_cnt_reg;
  logic                    start_pulse;

  xcvr_access u_access (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .req       (req_reg),
    .done      (acc_done),
    .rdata     (acc_rdata),
    .dev_stb   (dev_stb),
    .dev_cmd   (dev_cmd),
    .dev_we    (dev_we),
    .dev_addr  (dev_addr),
    .dev_wdata (dev_wdata),
    .dev_ack   (dev_ack),
    .dev_rdata (dev_rdata)
  );

  assign start_pulse = psel && penable && pwrite && (paddr == rf_check_pkg::REG_CTRL_OFS)
                       && pwdata[rf_check_pkg::CTRL_START_BIT];

  // APB register writes, one-cycle answer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_reg       <= 32'h0000_0000;
      backoff_ms_reg <= rf_check_pkg::BACKOFF_RESET_MS;
    end else if (psel && penable && pwrite) begin
      if (paddr == rf_check_pkg::REG_CTRL_OFS) begin
        ctrl_reg <= {28'h0000000, pwdata[3:1], 1'b0};
      end else if (paddr == rf_check_pkg::REG_BACKOFF_OFS) begin
        backoff_ms_reg <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0000_0000;
        unique case (paddr)
          rf_check_pkg::REG_CTRL_OFS:    prdata <= ctrl_reg;
          rf_check_pkg::REG_BACKOFF_OFS: prdata <= {16'h0000, backoff_ms_reg};
          rf_check_pkg::REG_STATUS_OFS:  prdata <= {20'h00000, 1'b0, tech_idx_reg,
                                                    backed_off_reg, out_target_reg,
                                                    out_field_reg, 1'b0, state_reg};
          rf_check_pkg::REG_RESULT_OFS:  prdata <= {29'h00000000, code_reg};
          default: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // Free-running polling period counter
  // period tick generation
  always_ff @(posedge clk) begin
    if (sys_rst || period_tick) begin
      period_cnt_reg <= 32'h0000_0000;
    end else begin
      period_cnt_reg <= period_cnt_reg + 32'h0000_0001;
    end
  end
  assign period_tick = (period_cnt_reg == 32'(PERIOD_MS * MS_CYCLES - 1));

  // Main sequence
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg      <= S_IDLE;
      req_reg        <= '0;
      req_busy_reg   <= 1'b0;
      cnt_reg        <= 32'h0000_0000;
      ms_left_reg    <= 16'h0000;
      code_reg       <= 3'h0;
      backed_off_reg <= 1'b0;
      tech_idx_reg   <= 3'h0;
      slot_cnt_reg   <= 32'h0000_0000;
      out_field_reg  <= 1'b0;
      out_target_reg <= 1'b1;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          out_field_reg <= 1'b0;
          if (start_pulse || period_tick) begin
            state_reg <= S_RXCFG;
          end
        end
        S_RXCFG: begin
          out_field_reg <= 1'b0;
          if (!req_busy_reg) begin
            req_reg <= '{valid: 1'b1, is_cmd: 1'b0, is_read: 1'b0,
                         addr: rf_check_pkg::XCVR_CHIP_CTRL_ADDR,
                         data: ctrl_reg[rf_check_pkg::CTRL_5V_BIT] ? rf_check_pkg::CHIP_CTRL_RX_ONLY_5V
                                                                  : rf_check_pkg::CHIP_CTRL_RX_ONLY_3V};
            req_busy_reg <= 1'b1;
          end else if (acc_done) begin
            req_reg.valid <= 1'b0;
            req_busy_reg  <= 1'b0;
            state_reg     <= S_TEST;
          end
        end
        S_TEST: begin
          if (!req_busy_reg) begin
            req_reg <= '{valid: 1'b1, is_cmd: 1'b1, is_read: 1'b0,
                         addr: 5'h00, data: rf_check_pkg::CMD_TEST_EXT_FIELD};
            req_busy_reg <= 1'b1;
          end else if (acc_done) begin
            req_reg.valid <= 1'b0;
            req_busy_reg  <= 1'b0;
            cnt_reg       <= 32'h0000_0000;
            state_reg     <= S_WAIT;
          end
        end
        S_WAIT: begin
          cnt_reg <= cnt_reg + 32'h0000_0001;
          if (cnt_reg == 32'(MEAS_CYC - 1)) begin
            state_reg <= S_READ;
          end
        end
        S_READ: begin
          if (!req_busy_reg) begin
            req_reg <= '{valid: 1'b1, is_cmd: 1'b0, is_read: 1'b1,
                         addr: rf_check_pkg::XCVR_FIELD_LEVEL_ADDR, data: 8'h00};
            req_busy_reg <= 1'b1;
          end else if (acc_done) begin
            req_reg.valid <= 1'b0;
            req_busy_reg  <= 1'b0;
            code_reg      <= acc_rdata[rf_check_pkg::FIELD_CODE_MSB:0];
            state_reg     <= S_DECIDE;
          end
        end
        // field stays off on nonzero code
        S_DECIDE: begin
          if (code_reg != rf_check_pkg::FIELD_CODE_QUIET) begin
            out_target_reg <= 1'b1;
            out_field_reg  <= 1'b0;
            backed_off_reg <= 1'b1;
            ms_left_reg    <= backoff_ms_reg;
            cnt_reg        <= 32'h0000_0000;
            state_reg      <= S_BACKOFF;
          end else begin
            out_target_reg <= 1'b0;
            out_field_reg  <= 1'b1;
            backed_off_reg <= 1'b0;
            tech_idx_reg   <= 3'h0;
            slot_cnt_reg   <= 32'h0000_0000;
            state_reg      <= S_POLL;
          end
        end
        S_BACKOFF: begin
          if (ms_left_reg == 16'h0000) begin
            state_reg <= S_RXCFG;
          end else if (cnt_reg == 32'(MS_CYCLES - 1)) begin
            cnt_reg     <= 32'h0000_0000;
            ms_left_reg <= ms_left_reg - 16'h0001;
          end else begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
          end
        end
        S_POLL: begin
          slot_cnt_reg <= slot_cnt_reg + 32'h0000_0001;
          if (slot_cnt_reg == 32'(SLOT_CYCLES - 1)) begin
            slot_cnt_reg <= 32'h0000_0000;
            if (tech_idx_reg == 3'(rf_check_pkg::TECH_PASSIVE_V)) begin
              out_field_reg  <= 1'b0;
              out_target_reg <= 1'b1;
              state_reg      <= S_LISTEN;
            end else begin
              tech_idx_reg <= tech_idx_reg + 3'h1;
            end
          end
        end
        S_LISTEN: begin
          if (period_tick) begin
            state_reg <= S_RXCFG;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Poll slot descriptor for the current technology
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      poll_slot <= '0;
    end else begin
      poll_slot.valid <= (state_reg == S_POLL);
      poll_slot.tech  <= rf_check_pkg::tech_t'(tech_idx_reg);
      poll_slot.first_cmd <= 8'h00;
      unique case (rf_check_pkg::tech_t'(tech_idx_reg))
        rf_check_pkg::TECH_ACTIVE_A, rf_check_pkg::TECH_PASSIVE_A: begin
          poll_slot.first_cmd <= ctrl_reg[rf_check_pkg::CTRL_WAKEUP_BIT] ? rf_check_pkg::NFCA_WAKEUP_REQUEST
                                                                        : rf_check_pkg::NFCA_POLL_REQUEST;
          poll_slot.rate_kbps <= rf_check_pkg::RATE_TYPE_A_KBPS;
        end
        rf_check_pkg::TECH_PASSIVE_B: poll_slot.rate_kbps <= rf_check_pkg::RATE_TYPE_B_KBPS;
        rf_check_pkg::TECH_ACTIVE_F, rf_check_pkg::TECH_PASSIVE_F: begin
          poll_slot.rate_kbps <= ctrl_reg[rf_check_pkg::CTRL_F424_BIT] ? rf_check_pkg::RATE_F_HIGH_KBPS
                                                                      : rf_check_pkg::RATE_F_LOW_KBPS;
        end
        default: poll_slot.rate_kbps <= 10'h000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      field_on    <= 1'b0;
      target_mode <= 1'b1;
    end else begin
      field_on    <= out_field_reg;
      target_mode <= out_target_reg;
    end
  end

  // Assertions
  a_field_off_code: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == S_DECIDE && code_reg != 3'h0) |=> ##1 !field_on)
    else $error("field enabled despite external field");
  a_test_after_cfg: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == S_RXCFG && acc_done) |=> state_reg == S_TEST)
    else $error("test command did not follow configuration");
  a_wait_length: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(state_reg == S_WAIT) |-> (state_reg == S_WAIT)[*8])
    else $error("measurement wait too short");
  a_backoff_enter: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == S_DECIDE && code_reg != 3'h0) |=> state_reg == S_BACKOFF && backed_off_reg)
    else $error("nonzero code did not back off");
  a_clear_proceed: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == S_DECIDE && code_reg == 3'h0) |=> ##1 field_on && !target_mode)
    else $error("clear channel did not start polling");
  a_backoff_restart: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == S_BACKOFF && ms_left_reg == 16'h0000) |=> state_reg == S_RXCFG)
    else $error("backoff expiry did not restart check");
  a_tech_order: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == S_POLL && $changed(tech_idx_reg) && $past(state_reg) == S_POLL)
      |-> tech_idx_reg == $past(tech_idx_reg) + 3'h1)
    else $error("technology order broken");
  a_nfca_cmd: assert property (@(posedge clk) disable iff (sys_rst)
    (poll_slot.valid && poll_slot.tech == rf_check_pkg::TECH_PASSIVE_A && !ctrl_reg[2] && !$past(ctrl_reg[2]))
      |-> poll_slot.first_cmd == 8'h26)
    else $error("wrong NFC-A poll command");
  a_wait_exit: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == S_WAIT) ##1 (state_reg != S_WAIT) |-> cnt_reg == 32'(MEAS_CYC))
    else $error("measurement wait cut short");
  a_field_gate: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(field_on) |-> code_reg == rf_check_pkg::FIELD_CODE_QUIET)
    else $error("field switched on without quiet code");

endmodule

// ==== verif/xcvr_model.sv ====
// Behavioural transceiver seen through the strobe/ack device port.
// Assumes one clock and sync reset; ack latency set by the bench.
`timescale 1ns/1ns
module xcvr_model #(
  parameter logic [7:0] CTRL_RESET  = 8'h01,
  parameter logic [7:0] LEVEL_RESET = 8'h40
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Device port
  input  wire logic       dev_stb,
  input  wire logic       dev_cmd,
  input  wire logic       dev_we,
  input  wire logic [4:0] dev_addr,
  input  wire logic [7:0] dev_wdata,
  output logic            dev_ack,
  output logic [7:0]      dev_rdata,
  // Bench controls
  input  wire logic [3:0] lat,
  input  wire logic [2:0] ext_code
);
  logic [7:0] ctrl_reg;
  logic [7:0] level_reg;
  logic [7:0] last_reg;
  logic [7:0] rd_val;
  logic [3:0] wait_reg;
  logic       ack_reg;

  assign dev_ack = ack_reg;
  // Released data lines show the inverse of the last value
  assign dev_rdata = ack_reg ? rd_val : ~last_reg;

  always_comb begin
    rd_val = 8'h00;
    if (dev_addr == 5'h00) begin
      rd_val = ctrl_reg;
    end else if (dev_addr == 5'h0f) begin
      rd_val = level_reg;
    end
  end

  // One-cycle ack after lat waiting cycles
  always_ff @(posedge clk) begin
    if (sys_rst || ack_reg) begin
      ack_reg  <= 1'b0;
      wait_reg <= 4'h0;
    end else if (dev_stb && wait_reg >= lat) begin
      ack_reg <= 1'b1;
    end else if (dev_stb) begin
      wait_reg <= wait_reg + 4'h1;
    end
  end

  // latch field code on test command
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_reg  <= CTRL_RESET;
      level_reg <= LEVEL_RESET;
      last_reg  <= 8'h00;
    end else if (dev_stb && ack_reg) begin
      last_reg <= rd_val;
      if (dev_cmd && dev_wdata == 8'h19) begin
        level_reg <= {level_reg[7:3], ext_code};
      end else if (dev_we && !dev_cmd && dev_addr == 5'h00) begin
        ctrl_reg <= dev_wdata;
      end
    end
  end
endmodule

// ==== verif/tb.sv ====
// Self-checking bench: APB master, device model, port monitors.
// Assumes shortened ms, period and slot counts on the sequencer.
`timescale 1ns/1ns
module tb;
  localparam int MS   = 100;
  localparam int PER  = 50;
  localparam int SLOT = 4;
  logic                     clk;
  logic                     sys_rst;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic                     pready;
  logic                     pslverr;
  logic                     e;
  logic                     dev_stb;
  logic                     dev_cmd;
  logic                     dev_we;
  logic                     dev_ack;
  logic                     field_on;
  logic                     target_mode;
  logic                     fo_prev;
  logic                     pv;
  logic [7:0]               paddr;
  logic [7:0]               dev_wdata;
  logic [7:0]               dev_rdata;
  logic [7:0]               last_rd;
  logic [31:0]              pwdata;
  logic [31:0]              prdata;
  logic [31:0]              r;
  logic [4:0]               dev_addr;
  logic [3:0]               lat;
  logic [2:0]               ext_code;
  rf_check_pkg::tech_t      pt;
  rf_check_pkg::poll_slot_t poll_slot;
  rf_check_pkg::poll_slot_t sl_q[$];
  logic [14:0]              acc_q[$];
  int                       acc_t[$];
  int                       cyc;
  int                       errors;
  int                       n_tests;

  rf_collision_check_sequencer #(.MS_CYCLES(MS), .PERIOD_MS(PER), .SLOT_CYCLES(SLOT)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .dev_stb(dev_stb),
    .dev_cmd(dev_cmd), .dev_we(dev_we), .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_ack(dev_ack),
    .dev_rdata(dev_rdata), .field_on(field_on), .target_mode(target_mode), .poll_slot(poll_slot));

  xcvr_model i_dev (
    .clk(clk), .sys_rst(sys_rst), .dev_stb(dev_stb), .dev_cmd(dev_cmd), .dev_we(dev_we),
    .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_ack(dev_ack), .dev_rdata(dev_rdata),
    .lat(lat), .ext_code(ext_code));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task end_of_test;
    if (errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task waitq(input int which, input int n);
    while (((which == 0) ? acc_q.size() : sl_q.size()) < n) begin
      @(posedge clk);
    end
  endtask

  task chk_round(input int b, input logic [7:0] acmd, input logic [9:0] frate);
    for (int i = 0; i < 6; i++) begin
      chk(32'(sl_q[b+i].tech), 32'(i));
      if (i == 0 || i == 2) chk({24'h0, sl_q[b+i].first_cmd}, {24'h0, acmd});
      if (i == 0 || i == 2 || i == 3) chk({22'h0, sl_q[b+i].rate_kbps}, 32'h6a);
      if (i == 1 || i == 4) chk({22'h0, sl_q[b+i].rate_kbps}, {22'h0, frate});
    end
  endtask

  // Device accesses, poll slot starts and field switch-on
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (dev_stb === 1'b1 && dev_ack === 1'b1) begin
      acc_q.push_back({dev_cmd, dev_we, dev_addr, dev_wdata});
      acc_t.push_back(cyc);
      if (!dev_we && !dev_cmd) last_rd <= dev_rdata;
    end
    if (poll_slot.valid === 1'b1 && (pv !== 1'b1 || poll_slot.tech !== pt)) sl_q.push_back(poll_slot);
    pv <= poll_slot.valid;
    pt <= poll_slot.tech;
    if (field_on === 1'b1 && fo_prev !== 1'b1) chk({29'h0, last_rd[2:0]}, 32'h0);
    fo_prev <= field_on;
  end

  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    end_of_test;
  end

  initial begin
    sys_rst  = 1'b1;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h0;
    lat      = 4'h3;
    ext_code = 3'h5;
    cyc      = 0;
    errors   = 0;
    n_tests  = 0;
    pv       = 1'b0;
    fo_prev  = 1'b0;
    last_rd  = 8'h00;
    pt       = rf_check_pkg::TECH_ACTIVE_A;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk_bit(field_on, 1'b0);
    chk_bit(target_mode, 1'b1);
    apb(1'b0, rf_check_pkg::REG_STATUS_OFS, 32'h0);
    chk(r & 32'h60, 32'h40);
    apb(1'b0, rf_check_pkg::REG_BACKOFF_OFS, 32'h0);
    chk(r, 32'h0a);
    apb(1'b0, 8'h10, 32'h0);
    chk(r, 32'h0);
    chk_bit(e, 1'b1);
    apb(1'b1, rf_check_pkg::REG_BACKOFF_OFS, 32'h2);
    apb(1'b0, rf_check_pkg::REG_BACKOFF_OFS, 32'h0);
    chk(r, 32'h2);
    // Busy field, slow device, 5 V receive-only
    apb(1'b1, rf_check_pkg::REG_CTRL_OFS, 32'h3);
    waitq(0, 3);
    chk({17'h0, acc_q[0]}, 32'h2003);
    chk_bit(acc_q[1][14], 1'b1);
    chk({24'h0, acc_q[1][7:0]}, 32'h19);
    chk({25'h0, acc_q[2][14:8]}, 32'h0f);
    chk_bit(acc_t[2] - acc_t[1] >= 1000, 1'b1);
    repeat (3) @(posedge clk);
    apb(1'b0, rf_check_pkg::REG_RESULT_OFS, 32'h0);
    chk(r, 32'h5);
    apb(1'b0, rf_check_pkg::REG_STATUS_OFS, 32'h0);
    chk(r & 32'he0, 32'hc0);
    chk_bit(field_on, 1'b0);
    // Quiet field, prompt device: recheck after backoff, then poll
    ext_code <= 3'h0;
    lat      <= 4'h0;
    waitq(0, 4);
    chk({17'h0, acc_q[3]}, 32'h2003);
    chk_bit(acc_t[3] - acc_t[2] >= 2 * MS && acc_t[3] - acc_t[2] <= 2 * MS + 50, 1'b1);
    waitq(1, 6);
    chk_bit(field_on, 1'b1);
    chk_bit(target_mode, 1'b0);
    chk_round(0, 8'h26, 10'h0d4);
    repeat (4 * SLOT) @(posedge clk);
    chk_bit(target_mode, 1'b1);
    apb(1'b1, rf_check_pkg::REG_CTRL_OFS, 32'hc);
    apb(1'b0, rf_check_pkg::REG_CTRL_OFS, 32'h0);
    chk(r, 32'hc);
    waitq(1, 12);
    chk({17'h0, acc_q[6]}, 32'h2002);
    chk_round(6, 8'h52, 10'h1a8);
    waitq(0, 10);
    chk_bit(acc_t[9] - acc_t[6] >= 9 * PER * MS / 10 && acc_t[9] - acc_t[6] <= 11 * PER * MS / 10, 1'b1);
    end_of_test;
  end
endmodule
